//--- hw/rscc_top.sv
// remote serial config capture: strap latch, baud tick, remote-mode gate
// assumes switch levels are steady and synchronous to core_clk
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "rscc_regs.svh"

module rscc_top #(
  parameter int unsigned CLK_HZ = `RSCC_CLK_HZ,
  parameter int unsigned HOLD_CYCLES = `RSCC_HOLD_S * `RSCC_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire rscc_pkg::rscc_sw_t sw,
  input wire logic remote_btn,
  input wire logic enter_btn,
  input wire rscc_pkg::rscc_req_t req,
  output logic [31:0] rdata,
  output logic remote_if_en,
  output logic remote_mode,
  output logic mil_if_sel,
  output logic baud_tick,
  output logic [17:0] baud_rate_x10,
  output logic [7:0] unit_id,
  output logic disp_show,
  output logic cfg_valid
);

  // ==========================================================
  // baud selector decode
  // rate in tenths of a baud so that 134.5 stays exact
  function automatic logic [17:0] rate_x10(input logic [3:0] code);
    logic [17:0] r;
    r = 18'h0;
    case (code)
      4'h0: r = 18'h001F4;
      4'h1: r = 18'h002EE;
      4'h2: r = 18'h0044C;
      4'h3: r = 18'h00541;
      4'h4: r = 18'h005DC;
      4'h5: r = 18'h00BB8;
      4'h6: r = 18'h01770;
      4'h7: r = 18'h02EE0;
      4'h8: r = 18'h04650;
      4'h9: r = 18'h04E20;
      4'hA: r = 18'h05DC0;
      4'hC: r = 18'h0BB80;
      4'hD: r = 18'h11940;
      4'hE: r = 18'h17700;
      4'hF: r = 18'h2EE00;
      default: r = 18'h0;
    endcase
    return r;
  endfunction

  // clock cycles per bit; truncation error stays below one cycle
  function automatic logic [23:0] bit_cycles(input logic [3:0] code);
    logic [63:0] q;
    logic [17:0] r;
    r = rate_x10(code);
    q = 64'h0;
    if (r != 18'h0) begin
      q = (64'(CLK_HZ) * 64'hA) / 64'(r);
    end
    return q[23:0];
  endfunction

  // ==========================================================
  // state
  rscc_pkg::rscc_state_t s_r;
  rscc_pkg::rscc_state_t s_nxt;

  logic en;
  logic type_ok;
  logic [23:0] div;
  logic [31:0] rd_val;

  // closed switch pulls low, so a 0 enables
  assign en = ~sw.cfg_bank[`RSCC_EN_BIT];

  // third switch masked out of the type compare
  assign type_ok = ((sw.cfg_bank & `RSCC_TYPE_MASK) == `RSCC_TYPE_VALUE)
                   && sw.jumper_2_3;

  assign div = bit_cycles(s_r.baud_code);

  // ==========================================================
  // register read mux
  always_comb begin
    rd_val = 32'h0;
    case (req.addr)
      `RSCC_ADDR_STATUS: begin
        rd_val = {25'h0, s_r.phase == rscc_pkg::RSCC_RUN, s_r.show, s_r.fallback,
                  type_ok, s_r.remote_mode, en, 1'b1};
      end
      `RSCC_ADDR_ID: rd_val = {24'h0, s_r.unit_id};
      `RSCC_ADDR_BAUD: rd_val = {10'h0, rate_x10(s_r.baud_code), s_r.baud_code};
      `RSCC_ADDR_CTRL: rd_val = {31'h0, s_r.force_local};
      default: rd_val = 32'h0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.baud_tick = 1'b0;
    s_nxt.rdata = 32'h0;

    case (s_r.phase)
      rscc_pkg::RSCC_CAPTURE: begin
        // first edge after reset release is the only sampling point
        s_nxt.unit_id = sw.id_bank;
        if (sw.baud_sel == `RSCC_BAUD_UNASSIGNED) begin
          s_nxt.baud_code = `RSCC_BAUD_DEFAULT;
          s_nxt.fallback = 1'b1;
        end else begin
          s_nxt.baud_code = sw.baud_sel;
          s_nxt.fallback = 1'b0;
        end
        s_nxt.phase = rscc_pkg::RSCC_RUN;
      end
      rscc_pkg::RSCC_RUN: begin
        // bit-rate tick only while the interface is enabled
        if (!en) begin
          s_nxt.baud_cnt = 24'h0;
        end else if (s_r.baud_cnt >= div - 24'h1) begin
          s_nxt.baud_cnt = 24'h0;
          s_nxt.baud_tick = 1'b1;
        end else begin
          s_nxt.baud_cnt = s_r.baud_cnt + 24'h1;
        end
      end
      default: s_nxt.phase = rscc_pkg::RSCC_CAPTURE;
    endcase

    // software control write
    if (req.wr && req.addr == `RSCC_ADDR_CTRL) begin
      s_nxt.force_local = req.wdata[`RSCC_CTRL_FORCE_LOCAL];
    end

    // front-panel remote button toggles local/remote
    if (!en || s_r.force_local) begin
      s_nxt.remote_mode = 1'b0;
    end else if (remote_btn && s_r.phase == rscc_pkg::RSCC_RUN) begin
      s_nxt.remote_mode = ~s_r.remote_mode;
    end

    // enter held in remote mode shows the latched values until release
    if (s_r.remote_mode && enter_btn) begin
      if (s_r.hold_cnt >= HOLD_CYCLES - 32'h1) begin
        s_nxt.show = 1'b1;
      end else begin
        s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
      end
    end else begin
      s_nxt.hold_cnt = 32'h0;
      s_nxt.show = 1'b0;
    end

    if (req.rd) begin
      s_nxt.rdata = rd_val;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{phase: rscc_pkg::RSCC_CAPTURE, unit_id: 8'h00, baud_code: 4'h0,
               fallback: 1'b0, remote_mode: 1'b0, hold_cnt: 32'h0, show: 1'b0,
               baud_cnt: 24'h0, baud_tick: 1'b0, force_local: 1'b0, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rdata = s_r.rdata;
  assign remote_if_en = en;
  assign remote_mode = s_r.remote_mode;
  assign mil_if_sel = en && type_ok;
  assign baud_tick = s_r.baud_tick;
  assign baud_rate_x10 = rate_x10(s_r.baud_code);
  assign unit_id = s_r.unit_id;
  assign disp_show = s_r.show;
  assign cfg_valid = s_r.phase == rscc_pkg::RSCC_RUN;

endmodule // rscc_top

//--- hw/rscc_regs.svh
// register offsets, field positions and timing figures of the remote serial config capture
// assumes a byte-addressed plain register port with 32-bit data
//
// Behaviour
// - serial interface enabled when enable switch is closed, disabled when open.
// - remote-mode button is ignored while the interface is disabled.
// - third configuration switch is ignored; installer leaves it closed.
// - baud rate decodes from one sixteen-position hex selector, positions 0 to F.
// - positions map 50..19200 baud as tabled; position B has no rate.
// - unit identifier is eight bits, one bit per identifier switch.
// - identifier bit is one for an open switch, zero for a closed one.
// - first switch weighs 1, eighth weighs 128; first switch is the lsb.
// - every identifier value 0 to 255 is accepted.
// - identifier and baud switches sampled only after reset; later changes wait.
// - in remote mode, enter held ten seconds shows identifier and baud rate.
`ifndef RSCC_REGS_SVH
`define RSCC_REGS_SVH

// ==========================================================
// register map (byte addresses)
`define RSCC_ADDR_STATUS 8'h00
`define RSCC_ADDR_ID 8'h04
`define RSCC_ADDR_BAUD 8'h08
`define RSCC_ADDR_CTRL 8'h0C

// ==========================================================
// switch bank fields, switch n at bit n-1; a pin reads 1 when open
`define RSCC_EN_BIT 0
`define RSCC_UNUSED_BIT 2
// enable (switch 1) and spare (switch 3) stay out of the type compare
`define RSCC_TYPE_MASK 8'hFA
`define RSCC_TYPE_VALUE 8'hCA
`define RSCC_CTRL_FORCE_LOCAL 0

// ==========================================================
// baud selector codes and timing
`define RSCC_BAUD_UNASSIGNED 4'hB
`define RSCC_BAUD_DEFAULT 4'hE
`define RSCC_HOLD_S 10
`define RSCC_CLK_HZ 100000000

`endif

//--- hw/rscc_pkg.sv
// types of the remote serial config capture
// assumes rscc_regs.svh supplies the numeric constants
package rscc_pkg;

  typedef enum logic {RSCC_CAPTURE, RSCC_RUN} rscc_phase_t;

  // raw switch and jumper levels, a 1 means open
  typedef struct packed {
    logic [7:0] cfg_bank;
    logic [3:0] baud_sel;
    logic [7:0] id_bank;
    logic jumper_2_3;
  } rscc_sw_t;

  // plain register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rscc_req_t;

  typedef struct packed {
    rscc_phase_t phase;
    logic [7:0] unit_id;
    logic [3:0] baud_code;
    logic fallback;
    logic remote_mode;
    logic [31:0] hold_cnt;
    logic show;
    logic [23:0] baud_cnt;
    logic baud_tick;
    logic force_local;
    logic [31:0] rdata;
  } rscc_state_t;

endpackage

//--- verification/rscc_properties.sv
// checker for the remote serial config capture ports
// assumes a bind onto rscc_top and rscc_regs.svh on the include path
`timescale 1ns/10ps
`include "rscc_regs.svh"
module rscc_properties #(
  parameter int unsigned HOLD_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire rscc_pkg::rscc_sw_t sw,
  input wire logic remote_btn,
  input wire logic enter_btn,
  input wire rscc_pkg::rscc_req_t req,
  input wire logic [31:0] rdata,
  input wire logic remote_if_en,
  input wire logic remote_mode,
  input wire logic [17:0] baud_rate_x10,
  input wire logic [7:0] unit_id,
  input wire logic disp_show,
  input wire logic cfg_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // enter-held span; the bench holds far below 255 so no wrap
  logic [7:0] hold_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_r <= 8'h00;
    end else begin
      hold_r <= (remote_mode && enter_btn) ? hold_r + 8'h01 : 8'h00;
    end
  end
  AST_EN_SWITCH: assert property (remote_if_en == !sw.cfg_bank[`RSCC_EN_BIT])
    else $error("enable does not follow switch");
  AST_DISABLED_LOCAL: assert property (!remote_if_en |=> !remote_mode)
    else $error("remote mode while disabled");
  AST_MODE_NEEDS_PRESS: assert property ($rose(remote_mode) |-> $past(remote_btn && remote_if_en))
    else $error("remote mode without enabled press");
  AST_ID_CAPTURE: assert property ($rose(cfg_valid) |-> unit_id == $past(sw.id_bank))
    else $error("captured id differs from switches");
  AST_ID_HELD: assert property (cfg_valid && $past(cfg_valid) |-> $stable(unit_id) && $stable(baud_rate_x10))
    else $error("latched settings changed in run");
  AST_SHOW_BOUND: assert property (hold_r == 8'(HOLD_CYCLES + 3) |-> disp_show)
    else $error("display not shown after hold");
  AST_SHOW_DROP: assert property (disp_show && !enter_btn |=> !disp_show)
    else $error("display kept after release");
  AST_READ_ID: assert property ($past(req.rd) && $past(req.addr) == `RSCC_ADDR_ID |-> rdata == {24'h000000, unit_id})
    else $error("id read mismatch");
endmodule // rscc_properties

bind rscc_top rscc_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.core_clk(core_clk), .rst(rst),
  .sw(sw), .remote_btn(remote_btn), .enter_btn(enter_btn), .req(req), .rdata(rdata),
  .remote_if_en(remote_if_en), .remote_mode(remote_mode), .baud_rate_x10(baud_rate_x10),
  .unit_id(unit_id), .disp_show(disp_show), .cfg_valid(cfg_valid));

//--- verification/rscc_strap_model.sv
// switch bank, selector and jumper as an installer sets them
// assumes the bench gives the installer choices as plain levels
`timescale 1ns/10ps
module rscc_strap_model (
  input wire logic en_closed,
  input wire logic spare_open,
  input wire logic [3:0] baud_pos,
  input wire logic [7:0] id_open,
  output rscc_pkg::rscc_sw_t sw
);
  // type switches open,open,closed,closed,open,open and jumper 2-3; spare closed unless told
  assign sw = {4'hC, 1'b1, spare_open, 1'b1, ~en_closed, baud_pos, id_open, 1'b1};
endmodule // rscc_strap_model

//--- verification/remote_serial_config_capture_tb_top.sv
// bench for the remote serial config capture
// assumes rscc_strap_model stands in for the switch side
`timescale 1ns/10ps
`include "rscc_regs.svh"
module remote_serial_config_capture_tb_top;
  localparam int unsigned HOLD = 8;
  // small clock figure keeps bit periods short
  localparam int unsigned HZ = 100000;
  logic core_clk = 1'b0, rst = 1'b1, remote_btn = 1'b0, enter_btn = 1'b0, en_c = 1'b1, spare = 1'b0;
  logic [3:0] baud = 4'h0;
  logic [7:0] idv = 8'h00;
  rscc_pkg::rscc_sw_t sw;
  rscc_pkg::rscc_req_t req = '0;
  logic [31:0] rdata, d;
  logic en, rmode, mil, tick, show, valid;
  logic [17:0] rate;
  logic [7:0] uid;
  int fail_count = 0, checked = 0;
  logic [17:0] rates [16] = '{18'h001F4, 18'h002EE, 18'h0044C, 18'h00541, 18'h005DC, 18'h00BB8,
    18'h01770, 18'h02EE0, 18'h04650, 18'h04E20, 18'h05DC0, 18'h17700, 18'h0BB80, 18'h11940,
    18'h17700, 18'h2EE00};
  initial forever #5 core_clk = ~core_clk;
  rscc_strap_model u_strap (.en_closed(en_c), .spare_open(spare), .baud_pos(baud), .id_open(idv),
    .sw(sw));
  rscc_top #(.CLK_HZ(HZ), .HOLD_CYCLES(HOLD)) dut (.core_clk(core_clk), .rst(rst), .sw(sw),
    .remote_btn(remote_btn), .enter_btn(enter_btn), .req(req), .rdata(rdata), .remote_if_en(en),
    .remote_mode(rmode), .mil_if_sel(mil), .baud_tick(tick), .baud_rate_x10(rate), .unit_id(uid),
    .disp_show(show), .cfg_valid(valid));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic reboot();
    @(posedge core_clk) rst <= 1'b1;
    @(posedge core_clk) rst <= 1'b0;
    cyc(2);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk) req <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(posedge core_clk) req <= '0;
    #1 d = rdata;
  endtask
  task automatic press();
    @(posedge core_clk) remote_btn <= 1'b1;
    @(posedge core_clk) remote_btn <= 1'b0;
    cyc(1);
  endtask
  task automatic t_baud();
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk) baud <= 4'(i);
      reboot();
      chk("baud_rate_x10", 32'(rates[i]), 32'(rate));
    end
  endtask
  task automatic t_id();
    logic [7:0] ids [5] = '{8'h00, 8'hFF, 8'h01, 8'h80, 8'h5A};
    foreach (ids[i]) begin
      @(posedge core_clk) idv <= ids[i];
      reboot();
      chk("unit_id", 32'(ids[i]), 32'(uid));
      bus(1'b0, `RSCC_ADDR_ID, 32'h0);
      chk("id_read", 32'(ids[i]), d);
      @(posedge core_clk) idv <= ~ids[i];
      cyc(3);
      chk("unit_id_held", 32'(ids[i]), 32'(uid));
    end
  endtask
  task automatic t_remote();
    @(posedge core_clk) spare <= 1'b1;
    cyc(1);
    chk("mil_if_sel", 32'h1, 32'(mil));
    spare <= 1'b0;
    press();
    chk("remote_mode_on", 32'h1, 32'(rmode));
    bus(1'b1, `RSCC_ADDR_CTRL, 32'h1);
    cyc(1);
    chk("remote_mode_forced", 32'h0, 32'(rmode));
    bus(1'b1, `RSCC_ADDR_CTRL, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped_read", 32'h0, d);
    @(posedge core_clk) en_c <= 1'b0;
    press();
    chk("remote_mode_locked", 32'h0, 32'(rmode));
    chk("remote_if_en", 32'h0, 32'(en));
    @(posedge core_clk) en_c <= 1'b1;
  endtask
  task automatic t_show();
    press();
    @(posedge core_clk) enter_btn <= 1'b1;
    cyc(HOLD - 2);
    chk("disp_show_early", 32'h0, 32'(show));
    cyc(5);
    chk("disp_show", 32'h1, 32'(show));
    enter_btn <= 1'b0;
    cyc(2);
    chk("disp_show_off", 32'h0, 32'(show));
    press();
  endtask
  task automatic t_tick();
    int n;
    @(posedge core_clk) baud <= 4'hF;
    reboot();
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tick !== 1'b1 && n < 100);
    chk("tick_period", 10 * HZ / 192000, n);
  endtask
  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    cyc(2);
    t_baud();
    t_id();
    t_remote();
    t_show();
    t_tick();
    print_verdict();
  end
  initial begin
    #300000;
    fail_count++;
    print_verdict();
  end
endmodule // remote_serial_config_capture_tb_top
